/* File: hdl/wcb_cfg_regs.sv */
// axi4-lite register file for the watchdog and pin configuration bytes
// assumes a single master, one write and one read outstanding at most
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "wcb_defines.svh"
module wcb_cfg_regs #(
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rstn,
  // axi4-lite write address
  input  wire logic [AW-1:0] awaddr,
  input  wire logic [2:0]    awprot,
  input  wire logic          awvalid,
  output logic               awready,
  // axi4-lite write data
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  // axi4-lite write response
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // axi4-lite read address
  input  wire logic [AW-1:0] araddr,
  input  wire logic [2:0]    arprot,
  input  wire logic          arvalid,
  output logic               arready,
  // axi4-lite read data
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // oscillator status
  input  wire logic          hfOscStable,
  // decoded configuration levels
  output logic               wdogEnable,
  output logic [3:0]         postscaleShift,
  output logic [15:0]        postscaleRatio,
  output logic               masterClearPinEnable,
  output logic               portE3Enable,
  output logic               sysClockRun,
  output logic               t1OscLowPower,
  output logic               portBAnalog,
  output logic               ccp2PinSelect
);

  // the map needs four words of address space
  if (AW < 4 || AW > 32) begin : g_bad_aw
    $error("wcb_cfg_regs: AW must lie in 4..32");
  end

  // held state
  wcb_pkg::wcb_byte_t wdogCfg;
  wcb_pkg::wcb_byte_t pinCfg;
  logic               swWdogEnable;
  logic [AW-1:0]      awAddrHeld;
  logic [31:0]        wDataHeld;
  logic               wLaneHeld;

  // word decode shared by both channels
  function automatic logic mapped(input logic [31:0] a);
    mapped = a == `WCB_OFS_WDOG_CFG || a == `WCB_OFS_PIN_CFG ||
             a == `WCB_OFS_WDOG_CTRL || a == `WCB_OFS_STATUS;
  endfunction

  function automatic logic [1:0] respFor(input logic [31:0] a);
    respFor = mapped(a) ? 2'(wcb_pkg::WCB_OKAY) : 2'(wcb_pkg::WCB_SLVERR);
  endfunction

  // write path: both halves held, then one commit cycle
  wire [31:0] wAddrFull  = 32'(awAddrHeld);
  wire        writeFire  = ~awready & ~wready & ~bvalid;
  wire        wrLane     = writeFire & wLaneHeld;
  wire        wrWdogCfg  = wrLane & (wAddrFull == `WCB_OFS_WDOG_CFG);
  wire        wrPinCfg   = wrLane & (wAddrFull == `WCB_OFS_PIN_CFG);
  wire        wrCtrl     = wrLane & (wAddrFull == `WCB_OFS_WDOG_CTRL);
  wire        awTaken    = awvalid & awready;
  wire        wTaken     = wvalid & wready;
  wire        bDone      = bvalid & bready;

  // read path
  wire [31:0] rAddrFull  = 32'(araddr);
  wire        arTaken    = arvalid & arready;
  wire        rDone      = rvalid & rready;
  wire [31:0] statusWord = {28'h0000000, hfOscStable, masterClearPinEnable, sysClockRun, wdogEnable};
  // unimplemented bits are never stored, and masked again on the way out
  wire [31:0] next_rdata =
    rAddrFull == `WCB_OFS_WDOG_CFG  ? {24'h000000, wdogCfg & `WCB_WDOG_IMPL_MASK} :
    rAddrFull == `WCB_OFS_PIN_CFG   ? {24'h000000, pinCfg & `WCB_PIN_IMPL_MASK} :
    rAddrFull == `WCB_OFS_WDOG_CTRL ? {31'h00000000, swWdogEnable} :
    rAddrFull == `WCB_OFS_STATUS    ? statusWord : 32'h00000000;

  // write address and data capture; each side accepts alone
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      awAddrHeld <= '0;
      wDataHeld  <= 32'h00000000;
      wLaneHeld  <= 1'b0;
    end else begin
      if (awTaken) begin
        awready    <= 1'b0;
        awAddrHeld <= awaddr;
      end else if (bDone) begin
        awready <= 1'b1;
      end
      if (wTaken) begin
        wready    <= 1'b0;
        wDataHeld <= wdata;
        wLaneHeld <= wstrb[0];
      end else if (bDone) begin
        wready <= 1'b1;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp  <= 2'(wcb_pkg::WCB_OKAY);
    end else if (writeFire) begin
      bvalid <= 1'b1;
      bresp  <= respFor(wAddrFull);
    end else if (bDone) begin
      bvalid <= 1'b0;
    end
  end

  // configuration bytes; only lane 0 carries data, upper bits dropped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdogCfg      <= `WCB_WDOG_RESET;
      pinCfg       <= `WCB_PIN_RESET;
      swWdogEnable <= `WCB_CTRL_RESET;
    end else begin
      if (wrWdogCfg) wdogCfg <= wDataHeld[7:0] & `WCB_WDOG_IMPL_MASK;
      if (wrPinCfg) pinCfg <= wDataHeld[7:0] & `WCB_PIN_IMPL_MASK;
      if (wrCtrl) swWdogEnable <= wDataHeld[`WCB_CTRL_SWEN_BIT];
    end
  end

  // read channel: data registered in the cycle after the address is taken
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= 2'(wcb_pkg::WCB_OKAY);
    end else if (arTaken) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= next_rdata;
      rresp   <= respFor(rAddrFull);
    end else if (rDone) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // decode of the stored bytes into control levels
  wcb_cfg_decode u_decode (
    .mclk           (mclk),
    .rstn           (rstn),
    .wdogCfg        (wdogCfg),
    .pinCfg         (pinCfg),
    .swWdogEnable   (swWdogEnable),
    .hfOscStable    (hfOscStable),
    .wdogEnable     (wdogEnable),
    .postscaleShift (postscaleShift),
    .postscaleRatio (postscaleRatio),
    .masterClearPinEnable (masterClearPinEnable),
    .portE3Enable   (portE3Enable),
    .sysClockRun    (sysClockRun),
    .t1OscLowPower  (t1OscLowPower),
    .portBAnalog    (portBAnalog),
    .ccp2PinSelect  (ccp2PinSelect)
  );

  // bus and register checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_rsv_wdog;
    arTaken && rAddrFull == `WCB_OFS_WDOG_CFG |=> rvalid && rdata[31:5] == 27'h0000000;
  endproperty
  a_rsv_wdog: assert property (p_rsv_wdog) else $error("watchdog byte upper bits not zero");

  property p_rsv_pin;
    arTaken && rAddrFull == `WCB_OFS_PIN_CFG |=> rvalid && rdata[6:4] == 3'h0 && rdata[31:8] == 24'h000000;
  endproperty
  a_rsv_pin: assert property (p_rsv_pin) else $error("pin byte unimplemented bits not zero");

  property p_wr_resp;
    writeFire |=> bvalid ##0 (bresp == 2'h0) == mapped($past(wAddrFull));
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late or wrong");

  property p_rd_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && !arready;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped before taken");

  property p_force_path;
    wrWdogCfg && wDataHeld[0] |=> ##1 wdogEnable;
  endproperty
  a_force_path: assert property (p_force_path) else $error("written force bit not applied");

  c_write:  cover property (awTaken && wTaken ##1 writeFire ##1 bvalid);
  c_read:   cover property (arTaken ##1 rvalid && rready);
  c_unmap:  cover property (arTaken && !mapped(rAddrFull));
endmodule

/* File: inc/wcb_defines.svh */
// constants of the watchdog and pin configuration register block
// assumes a 32-bit axi4-lite slave with byte registers in lane 0
`ifndef WCB_DEFINES_SVH
`define WCB_DEFINES_SVH

// register byte offsets
`define WCB_OFS_WDOG_CFG     32'h0000_0000
`define WCB_OFS_PIN_CFG      32'h0000_0004
`define WCB_OFS_WDOG_CTRL    32'h0000_0008
`define WCB_OFS_STATUS       32'h0000_000c

// watchdog configuration byte fields
`define WCB_WDOG_FORCE_BIT   0
`define WCB_WDOG_PS_LSB      1
`define WCB_WDOG_PS_MSB      4
`define WCB_WDOG_IMPL_MASK   8'h1f
`define WCB_WDOG_RESET       8'h1f

// pin and oscillator configuration byte fields
`define WCB_PIN_CCP2_BIT     0
`define WCB_PIN_PORTB_BIT    1
`define WCB_PIN_T1LP_BIT     2
`define WCB_PIN_FAST_BIT     3
`define WCB_PIN_MSTCLR_BIT   7
`define WCB_PIN_IMPL_MASK    8'h8f
`define WCB_PIN_RESET        8'h8b

// watchdog control and status fields
`define WCB_CTRL_SWEN_BIT    0
`define WCB_CTRL_RESET       1'b0
`define WCB_STAT_WDOG_BIT    0
`define WCB_STAT_CLKRUN_BIT  1
`define WCB_STAT_MSTCLR_BIT  2
`define WCB_STAT_STABLE_BIT  3

`endif

/* File: inc/wcb_pkg.sv */
// types shared by the configuration register block
// assumes wcb_defines.svh for all numeric constants
package wcb_pkg;
  typedef logic [7:0]  wcb_byte_t;
  typedef logic [15:0] wcb_ratio_t;
  // axi4-lite response codes in bus order
  typedef enum logic [1:0] {WCB_OKAY, WCB_EXOKAY, WCB_SLVERR, WCB_DECERR} wcb_resp_e;
endpackage

/* File: hdl/wcb_cfg_decode.sv */
// registered decode of the two configuration bytes into control levels
// assumes byte inputs stable from the register file, one clock domain
`timescale 1ns/100ps
`include "wcb_defines.svh"
module wcb_cfg_decode (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // configuration sources
  input  wire wcb_pkg::wcb_byte_t wdogCfg,
  input  wire wcb_pkg::wcb_byte_t pinCfg,
  input  wire logic             swWdogEnable,
  input  wire logic             hfOscStable,
  // decoded levels
  output logic                  wdogEnable,
  output logic [3:0]            postscaleShift,
  output wcb_pkg::wcb_ratio_t   postscaleRatio,
  output logic                  masterClearPinEnable,
  output logic                  portE3Enable,
  output logic                  sysClockRun,
  output logic                  t1OscLowPower,
  output logic                  portBAnalog,
  output logic                  ccp2PinSelect
);

  // divide ratio is a plain two-power; code 15 gives 32768
  function automatic wcb_pkg::wcb_ratio_t ratioOf(input logic [3:0] code);
    ratioOf = 16'h0001 << code;
  endfunction

  // decode wires
  wire [3:0] psCode     = wdogCfg[`WCB_WDOG_PS_MSB:`WCB_WDOG_PS_LSB];
  wire       forceOn    = wdogCfg[`WCB_WDOG_FORCE_BIT];
  wire       next_wdog  = forceOn | swWdogEnable;
  wire       fastStart  = pinCfg[`WCB_PIN_FAST_BIT];
  wire       next_run   = fastStart | hfOscStable;

  // all outputs registered; reset values follow the unprogrammed bytes, except sysClockRun, which resets low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdogEnable     <= 1'b1;
      postscaleShift <= 4'hf;
      postscaleRatio <= 16'h8000;
      masterClearPinEnable <= 1'b1;
      portE3Enable   <= 1'b0;
      sysClockRun    <= 1'b0;
      t1OscLowPower  <= 1'b0;
      portBAnalog    <= 1'b1;
      ccp2PinSelect  <= 1'b1;
    end else begin
      wdogEnable     <= next_wdog;
      postscaleShift <= psCode;
      postscaleRatio <= ratioOf(psCode);
      masterClearPinEnable <= pinCfg[`WCB_PIN_MSTCLR_BIT];
      portE3Enable   <= ~pinCfg[`WCB_PIN_MSTCLR_BIT];
      sysClockRun    <= next_run;
      t1OscLowPower  <= pinCfg[`WCB_PIN_T1LP_BIT];
      portBAnalog    <= pinCfg[`WCB_PIN_PORTB_BIT];
      ccp2PinSelect  <= pinCfg[`WCB_PIN_CCP2_BIT];
    end
  end

  // checks on the decode
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_ratio;
    ##1 postscaleRatio == (16'h0001 << $past(wdogCfg[4:1])) && postscaleShift == $past(wdogCfg[4:1]);
  endproperty
  a_ratio: assert property (p_ratio) else $error("postscale ratio mismatch");

  property p_force;
    forceOn && !swWdogEnable |=> wdogEnable;
  endproperty
  a_force: assert property (p_force) else $error("forced watchdog not on");

  property p_soft;
    !forceOn |=> wdogEnable == $past(swWdogEnable);
  endproperty
  a_soft: assert property (p_soft) else $error("watchdog ignores software bit");

  property p_master_clear;
    ##1 masterClearPinEnable != portE3Enable && masterClearPinEnable == $past(pinCfg[`WCB_PIN_MSTCLR_BIT]);
  endproperty
  a_master_clear: assert property (p_master_clear) else $error("reset pin function wrong");

  property p_fast;
    fastStart |=> sysClockRun;
  endproperty
  a_fast: assert property (p_fast) else $error("fast start waited for oscillator");

  property p_hold;
    !fastStart && !hfOscStable |=> !sysClockRun;
  endproperty
  a_hold: assert property (p_hold) else $error("clock released before stable");

  c_sw_off: cover property (!forceOn && !swWdogEnable ##1 !wdogEnable);
  c_wait:   cover property (!sysClockRun ##1 sysClockRun);
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the configuration register block over axi4-lite
// assumes wcb_cfg_regs with default address width and the register map in wcb_defines.svh
`timescale 1ns/100ps
`include "wcb_defines.svh"
module tb_top;
  logic        mclk, rstn, hfOscStable;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, postscaleShift;
  logic [15:0] postscaleRatio;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        wdogEnable, masterClearPinEnable, portE3Enable, sysClockRun;
  logic        t1OscLowPower, portBAnalog, ccp2PinSelect;
  int          failures, checks, cycles;
  logic [7:0]  pinByte;
  logic        hfNext;

  wcb_cfg_regs uut (.mclk(mclk), .rstn(rstn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .hfOscStable(hfOscStable),
    .wdogEnable(wdogEnable), .postscaleShift(postscaleShift), .postscaleRatio(postscaleRatio),
    .masterClearPinEnable(masterClearPinEnable), .portE3Enable(portE3Enable), .sysClockRun(sysClockRun),
    .t1OscLowPower(t1OscLowPower), .portBAnalog(portBAnalog), .ccp2PinSelect(ccp2PinSelect));

  // 50 mhz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // a hung handshake would stall the run forever, so cap it well above the expected length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // value comparison
  task automatic checkVal(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // response code comparison
  task automatic checkResp(input string nm, input logic [1:0] exp, input logic [1:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s response expected %h seen %h", nm, exp, got);
    end
  endtask

  // let the one-edge lag of the decoded outputs land before sampling
  task automatic settle();
    @(posedge mclk);
    @(posedge mclk);
    #1;
  endtask

  // address and data offered together, each released at its own take
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er,
                          input string nm, input logic [3:0] s = 4'hf);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge mclk);
    awaddr <= a[7:0];
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready && !awDone) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready && !wDone) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        checkResp(nm, er, bresp);
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // read with rready held until the data is sampled
  task automatic axiRead(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er, input string nm);
    @(posedge mclk);
    araddr <= a[7:0];
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        checkVal(nm, ed, rdata);
        checkResp(nm, er, rresp);
        rready <= 1'b0;
        break;
      end
    end
  endtask

  initial begin
    failures = 0;
    checks = 0;
    cycles = 0;
    rstn = 1'b0;
    hfOscStable = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    settle();
    // unprogrammed bytes after release
    checkVal("wdogEnable", 1, wdogEnable);
    checkVal("postscaleRatio", 32'h8000, postscaleRatio);
    checkVal("sysClockRun", 1, sysClockRun);
    checkVal("masterClearPinEnable", 1, masterClearPinEnable);
    // bus handshakes idle after release
    checkVal("readyIdle", 32'h7, {29'h0, awready, wready, arready});
    checkVal("validIdle", 32'h0, {30'h0, bvalid, rvalid});
    axiRead(`WCB_OFS_WDOG_CFG, 32'h1f, wcb_pkg::WCB_OKAY, "wdogCfg");
    axiRead(`WCB_OFS_PIN_CFG, 32'h8b, wcb_pkg::WCB_OKAY, "pinCfg");
    axiRead(`WCB_OFS_WDOG_CTRL, 32'h0, wcb_pkg::WCB_OKAY, "wdogCtrl");
    // every postscale code, upper bits set to prove they do not stick
    for (int i = 0; i < 16; i++) begin
      axiWrite(`WCB_OFS_WDOG_CFG, 32'hffffffe0 | 32'(i << 1), wcb_pkg::WCB_OKAY, "wdogCfg");
      settle();
      checkVal("postscaleShift", 32'(i), {28'h0, postscaleShift});
      checkVal("postscaleRatio", 32'h1 << i, {16'h0, postscaleRatio});
      checkVal("wdogEnable", 0, wdogEnable);
      axiRead(`WCB_OFS_WDOG_CFG, 32'(i << 1), wcb_pkg::WCB_OKAY, "wdogCfg");
    end
    // force bit against software bit, all four pairings
    for (int k = 0; k < 4; k++) begin
      axiWrite(`WCB_OFS_WDOG_CFG, 32'(k & 1), wcb_pkg::WCB_OKAY, "wdogCfg");
      axiWrite(`WCB_OFS_WDOG_CTRL, 32'(k >> 1), wcb_pkg::WCB_OKAY, "wdogCtrl");
      settle();
      checkVal("wdogEnable", 32'((k & 1) | (k >> 1)), {31'h0, wdogEnable});
    end
    // pin byte combinations with the oscillator status toggling
    for (int j = 0; j < 32; j++) begin
      pinByte = {j[0], 3'b111, j[1], j[2], j[3], j[4]};
      hfNext = j[3] ^ j[1];
      hfOscStable <= hfNext;
      axiWrite(`WCB_OFS_PIN_CFG, {24'hffffff, pinByte}, wcb_pkg::WCB_OKAY, "pinCfg");
      settle();
      checkVal("masterClearPinEnable", 32'(j[0]), {31'h0, masterClearPinEnable});
      checkVal("portE3Enable", 32'(!j[0]), {31'h0, portE3Enable});
      checkVal("sysClockRun", 32'(j[1] | hfNext), {31'h0, sysClockRun});
      checkVal("t1OscLowPower", 32'(j[2]), {31'h0, t1OscLowPower});
      checkVal("portBAnalog", 32'(j[3]), {31'h0, portBAnalog});
      checkVal("ccp2PinSelect", 32'(j[4]), {31'h0, ccp2PinSelect});
      axiRead(`WCB_OFS_PIN_CFG, {24'h0, pinByte & 8'h8f}, wcb_pkg::WCB_OKAY, "pinCfg");
    end
    // status is read-only; last state has watchdog, clock and master clear on, oscillator not stable
    axiWrite(`WCB_OFS_STATUS, 32'h0, wcb_pkg::WCB_OKAY, "status");
    axiRead(`WCB_OFS_STATUS, 32'h7, wcb_pkg::WCB_OKAY, "status");
    // a stable oscillator shows in the top status bit
    hfOscStable <= 1'b1;
    axiRead(`WCB_OFS_STATUS, 32'hf, wcb_pkg::WCB_OKAY, "statusStable");
    // byte lane disabled leaves the pin byte alone
    axiWrite(`WCB_OFS_PIN_CFG, 32'h0, wcb_pkg::WCB_OKAY, "pinCfgNoStrobe", 4'he);
    axiRead(`WCB_OFS_PIN_CFG, 32'h8f, wcb_pkg::WCB_OKAY, "pinCfg");
    // unmapped place
    axiWrite(32'h10, 32'hff, wcb_pkg::WCB_SLVERR, "unmapped");
    axiRead(32'h10, 32'h0, wcb_pkg::WCB_SLVERR, "unmapped");
    results();
  end
endmodule
